// >>> pkg/tss_params.svh
// Constants for the tape subsystem status register block.
`ifndef TSS_PARAMS_SVH
`define TSS_PARAMS_SVH
// ==========================================
// Register offsets (byte offset from base)
`define TSS_OFS_DB   2'h0
`define TSS_OFS_SR   2'h2
// ==========================================
// Status bit positions
`define TSS_B_SC     15
`define TSS_B_UPE    14
`define TSS_B_SPE    13
`define TSS_B_RMR    12
`define TSS_B_NXM    11
`define TSS_B_NBA    10
`define TSS_B_AHI    9
`define TSS_B_ALO    8
`define TSS_B_SSR    7
`define TSS_B_OFL    6
`define TSS_B_FCHI   5
`define TSS_B_FCLO   4
`define TSS_B_TCHI   3
`define TSS_B_TCLO   1
// ==========================================
// Reset and fixed values
`define TSS_FLAG_RST 1'h0
`define TSS_NBA_RST  1'h1
`define TSS_TC_RST   3'h0
`define TSS_FC_RST   2'h0
`define TSS_AHI_RST  2'h0
`define TSS_PTR_RST  18'h00000
`define TSS_WORD_0   16'h0000
`define TSS_TC_FATAL 3'h7
`define TSS_FC_SPE   2'h2
`endif

// >>> pkg/tss_pkg.sv
// Types shared by the tape subsystem status register block.
package tss_pkg;
  typedef logic [15:0] tss_word_t;
  typedef logic [2:0]  tss_tc_t;
  typedef logic [1:0]  tss_fc_t;
  typedef logic [17:0] tss_ptr_t;
endpackage

// >>> rtl/tss_sync.sv
// Two-stage synchroniser for a level arriving on a pin.
`timescale 1ns/1ps
`include "tss_params.svh"
module tss_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  // ==========================================
  // Next values: first stage feeds only the second.
  always_comb
  begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  // Registers.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= `TSS_FLAG_RST;
      q_o    <= `TSS_FLAG_RST;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_o    <= q_nxt;
    end
  end
endmodule

// >>> rtl/tss_host_port.sv
// Host access decoder: turns a strobed access into per-register pulses.
`timescale 1ns/1ps
`include "tss_params.svh"
module tss_host_port
(
  input  wire logic       sel_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       byte_i,
  input  wire logic [1:0] addr_i,
  output logic            db_word_o,
  output logic            db_hi_o,
  output logic            db_lo_o,
  output logic            sr_wr_o,
  output logic            sr_rd_o,
  output logic            any_o
);
  logic is_db;
  logic is_sr;

  // ==========================================
  // Address decode. Bit 0 of the address picks the odd byte on a byte write.
  always_comb
  begin
    is_db     = (addr_i & 2'h2) == `TSS_OFS_DB;
    is_sr     = (addr_i & 2'h2) == `TSS_OFS_SR;
    db_word_o = sel_i & wr_i & is_db & ~byte_i;
    db_hi_o   = sel_i & wr_i & is_db & byte_i & addr_i[0];
    db_lo_o   = sel_i & wr_i & is_db & byte_i & ~addr_i[0];
    sr_wr_o   = sel_i & wr_i & is_sr;
    sr_rd_o   = sel_i & rd_i & ~wr_i & is_sr;
    any_o     = sel_i & (wr_i | rd_i);
  end
endmodule

// >>> rtl/tss_status_top.sv
// Status register of the tape subsystem host interface.
`timescale 1ns/1ps
`include "tss_params.svh"
module tss_status_top
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        HOST_SEL_I,
  input  wire logic        HOST_WR_I,
  input  wire logic        HOST_RD_I,
  input  wire logic        HOST_BYTE_I,
  input  wire logic [1:0]  HOST_ADDR_I,
  input  wire logic [15:0] HOST_WDATA_I,
  output logic      [15:0] HOST_RDATA_O,
  output logic             HOST_ACK_O,
  input  wire logic        XPT_END_I,
  input  wire logic        XPT_SC_I,
  input  wire logic [2:0]  XPT_TC_I,
  input  wire logic [1:0]  XPT_FC_I,
  input  wire logic        XPT_IDLE_I,
  input  wire logic        XPT_NBA_CLR_I,
  input  wire logic        XPT_AHI_LD_I,
  input  wire logic [1:0]  XPT_AHI_I,
  input  wire logic        OFFLINE_PIN_I,
  input  wire logic        UPE_EV_I,
  input  wire logic        SPE_EV_I,
  input  wire logic        NXM_EV_I,
  output logic             INIT_O,
  output logic             CMD_LD_O,
  output logic      [17:0] CMD_PTR_O
);
  logic              db_word;
  logic              db_hi;
  logic              db_lo;
  logic              db_any;
  logic              sr_wr;
  logic              sr_rd;
  logic              acc;
  logic              offline;
  logic              sc_r,  sc_nxt;
  logic              upe_r, upe_nxt;
  logic              spe_r, spe_nxt;
  logic              rmr_r, rmr_nxt;
  logic              nxm_r, nxm_nxt;
  logic              nba_r, nba_nxt;
  logic              ssr_r, ssr_nxt;
  logic [1:0]        ahi_r, ahi_nxt;
  tss_pkg::tss_tc_t  tc_r,  tc_nxt;
  tss_pkg::tss_fc_t  fc_r,  fc_nxt;
  tss_pkg::tss_word_t status;
  tss_pkg::tss_word_t rdata_nxt;
  tss_pkg::tss_ptr_t ptr_nxt;
  logic              ack_nxt;
  logic              init_nxt;
  logic              ld_nxt;

  // ==========================================
  // Host access decode and off-line pin synchroniser.
  tss_host_port u_port
  (
    .sel_i     (HOST_SEL_I),
    .wr_i      (HOST_WR_I),
    .rd_i      (HOST_RD_I),
    .byte_i    (HOST_BYTE_I),
    .addr_i    (HOST_ADDR_I),
    .db_word_o (db_word),
    .db_hi_o   (db_hi),
    .db_lo_o   (db_lo),
    .sr_wr_o   (sr_wr),
    .sr_rd_o   (sr_rd),
    .any_o     (acc)
  );

  tss_sync u_ofl
  (
    .clk_i (CLK_SYS_I),
    .rst_i (SYS_RST_I),
    .d_i   (OFFLINE_PIN_I),
    .q_o   (offline)
  );

  // ==========================================
  // Live status word. Host data never reaches it except via the address bits.
  always_comb
  begin
    db_any = db_word | db_hi | db_lo;
    status = `TSS_WORD_0;
    status[`TSS_B_SC]  = sc_r;
    status[`TSS_B_UPE] = upe_r;
    status[`TSS_B_SPE] = spe_r;
    status[`TSS_B_RMR] = rmr_r;
    status[`TSS_B_NXM] = nxm_r;
    status[`TSS_B_NBA] = nba_r;
    status[`TSS_B_AHI:`TSS_B_ALO]   = ahi_r;
    status[`TSS_B_SSR] = ssr_r;
    status[`TSS_B_OFL] = offline;
    status[`TSS_B_FCHI:`TSS_B_FCLO] = fc_r;
    status[`TSS_B_TCHI:`TSS_B_TCLO] = tc_r;
  end

  // ==========================================
  // Flag next values. Events are applied after the clears so a set in the
  // same cycle as a buffer write wins. Initialize resets every flag but the
  // address pair and wins over everything, since the transport is restarted anyway.
  always_comb
  begin
    sc_nxt  = sc_r;
    upe_nxt = upe_r;
    spe_nxt = spe_r;
    rmr_nxt = rmr_r;
    nxm_nxt = nxm_r;
    nba_nxt = nba_r;
    ssr_nxt = ssr_r;
    ahi_nxt = ahi_r;
    tc_nxt  = tc_r;
    fc_nxt  = fc_r;
    if (sr_wr)
    begin
      sc_nxt  = `TSS_FLAG_RST;
      upe_nxt = `TSS_FLAG_RST;
      spe_nxt = `TSS_FLAG_RST;
      rmr_nxt = `TSS_FLAG_RST;
      nxm_nxt = `TSS_FLAG_RST;
      ssr_nxt = `TSS_FLAG_RST;
      nba_nxt = `TSS_NBA_RST;
      tc_nxt  = `TSS_TC_RST;
      fc_nxt  = `TSS_FC_RST;
    end
    else
    begin
      if (db_any)
      begin
        upe_nxt = `TSS_FLAG_RST;
        spe_nxt = `TSS_FLAG_RST;
        rmr_nxt = `TSS_FLAG_RST;
        nxm_nxt = `TSS_FLAG_RST;
        ssr_nxt = `TSS_FLAG_RST;
      end
      if (db_word)
        ahi_nxt = HOST_WDATA_I[1:0];
      else if (db_hi)
        ahi_nxt = HOST_WDATA_I[9:8];
      else if (XPT_AHI_LD_I)
        ahi_nxt = XPT_AHI_I;
      if (XPT_END_I)
      begin
        sc_nxt = XPT_SC_I;
        tc_nxt = XPT_TC_I;
        fc_nxt = XPT_FC_I;
      end
      if ((db_word | db_hi) && !ssr_r)
      begin
        rmr_nxt = 1'h1;
        sc_nxt  = 1'h1;
      end
      if (UPE_EV_I)
      begin
        upe_nxt = 1'h1;
        sc_nxt  = 1'h1;
      end
      if (NXM_EV_I)
      begin
        nxm_nxt = 1'h1;
        sc_nxt  = 1'h1;
      end
      if (SPE_EV_I)
      begin
        spe_nxt = 1'h1;
        sc_nxt  = 1'h1;
        tc_nxt  = `TSS_TC_FATAL;
        fc_nxt  = `TSS_FC_SPE;
      end
      if (XPT_NBA_CLR_I)
        nba_nxt = `TSS_FLAG_RST;
      if (XPT_IDLE_I && !db_any)
        ssr_nxt = 1'h1;
      else if (!XPT_IDLE_I)
        ssr_nxt = `TSS_FLAG_RST;
    end
  end

  // Flag registers.
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      sc_r  <= `TSS_FLAG_RST;
      upe_r <= `TSS_FLAG_RST;
      spe_r <= `TSS_FLAG_RST;
      rmr_r <= `TSS_FLAG_RST;
      nxm_r <= `TSS_FLAG_RST;
      nba_r <= `TSS_NBA_RST;
      ssr_r <= `TSS_FLAG_RST;
      ahi_r <= `TSS_AHI_RST;
      tc_r  <= `TSS_TC_RST;
      fc_r  <= `TSS_FC_RST;
    end
    else
    begin
      sc_r  <= sc_nxt;
      upe_r <= upe_nxt;
      spe_r <= spe_nxt;
      rmr_r <= rmr_nxt;
      nxm_r <= nxm_nxt;
      nba_r <= nba_nxt;
      ssr_r <= ssr_nxt;
      ahi_r <= ahi_nxt;
      tc_r  <= tc_nxt;
      fc_r  <= fc_nxt;
    end
  end

  // ==========================================
  // Host answer and transport strobes. The read data is captured in the
  // accepting cycle so that no bit can move between halves of the word.
  always_comb
  begin
    ack_nxt   = acc;
    rdata_nxt = HOST_RDATA_O;
    if (sr_rd)
      rdata_nxt = status;
    else if (acc)
      rdata_nxt = `TSS_WORD_0;
    init_nxt = sr_wr;
    ld_nxt   = db_word;
    ptr_nxt  = CMD_PTR_O;
    if (db_word)
      ptr_nxt = {HOST_WDATA_I[1:0], HOST_WDATA_I[15:2], 2'h0};
  end

  // Answer registers.
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      HOST_ACK_O   <= `TSS_FLAG_RST;
      HOST_RDATA_O <= `TSS_WORD_0;
      INIT_O       <= `TSS_FLAG_RST;
      CMD_LD_O     <= `TSS_FLAG_RST;
      CMD_PTR_O    <= `TSS_PTR_RST;
    end
    else
    begin
      HOST_ACK_O   <= ack_nxt;
      HOST_RDATA_O <= rdata_nxt;
      INIT_O       <= init_nxt;
      CMD_LD_O     <= ld_nxt;
      CMD_PTR_O    <= ptr_nxt;
    end
  end

  // ==========================================
  // Checks.
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_init_wr;
    sr_wr;
  endsequence

  sequence s_cleared;
    !upe_r && !spe_r && !rmr_r && !nxm_r && !ssr_r && nba_r;
  endsequence

  a_init_clears: assert property (s_init_wr |=> s_cleared ##0 INIT_O)
    else $error("initialize did not clear flags");
  a_db_clears: assert property (db_any && !sr_wr && !UPE_EV_I && !SPE_EV_I
      && !NXM_EV_I && ssr_r |=> !upe_r && !spe_r && !nxm_r && !ssr_r)
    else $error("buffer write did not clear flags");
  a_rmr_busy: assert property (db_word && !ssr_r && !sr_wr
      |=> rmr_r && sc_r)
    else $error("refused modification not flagged");
  a_addr_mirror: assert property (db_word && !sr_wr
      |=> status[`TSS_B_AHI:`TSS_B_ALO] == $past(HOST_WDATA_I[1:0]))
    else $error("address bits not mirrored");
  a_read_snap: assert property (sr_rd
      |=> HOST_ACK_O && HOST_RDATA_O == $past(status))
    else $error("status read not a snapshot");
  a_no_host_set: assert property (!UPE_EV_I && !SPE_EV_I && !NXM_EV_I && !sr_wr
      && !(db_word | db_hi) |=> !$rose(upe_r) && !$rose(rmr_r) && !$rose(nxm_r))
    else $error("host access set a flag");
  a_spe_fatal: assert property (SPE_EV_I && !sr_wr
      |=> spe_r && tc_r == `TSS_TC_FATAL && fc_r == `TSS_FC_SPE)
    else $error("serial parity class wrong");
  a_ssr_idle: assert property (ssr_r |-> $past(XPT_IDLE_I))
    else $error("ready while not idle");
  a_offline_bit: assert property ($rose(OFFLINE_PIN_I)
      |-> ##[2:3] status[`TSS_B_OFL])
    else $error("off-line bit late");
endmodule

// >>> tb/tss_xpt_model.sv
// Transport-side model that drives status reports into the block.
`timescale 1ns/1ps
module tss_xpt_model
(
  input  wire logic       clk_i,
  output logic            end_o,
  output logic            sc_o,
  output logic [2:0]      tc_o,
  output logic [1:0]      fc_o,
  output logic            idle_o,
  output logic            nba_clr_o,
  output logic            ahi_ld_o,
  output logic [1:0]      ahi_o,
  output logic            ofl_o,
  output logic [2:0]      ev_o
);
  // ==========================================
  // Quiet lines from time zero, so no report is seen before it is meant.
  initial
  begin
    {end_o, sc_o, tc_o, fc_o, idle_o, nba_clr_o, ahi_ld_o, ahi_o, ofl_o, ev_o} = '0;
  end
  // One-cycle event pulse: 0 host parity, 1 link parity, 2 missing memory.
  task automatic pulse_ev(input int idx);
    @(negedge clk_i);
    ev_o[idx] = 1'b1;
    @(negedge clk_i);
    ev_o = 3'h0;
  endtask
  // Command end report; the fatal kind only carries meaning for class seven.
  task automatic end_cmd(input logic sc, input logic [2:0] tc, input logic [1:0] fc);
    @(negedge clk_i);
    end_o = 1'b1;
    sc_o = sc;
    tc_o = tc;
    fc_o = (tc == 3'h7) ? fc : 2'h0;
    @(negedge clk_i);
    end_o = 1'b0;
  endtask
  // Set-characteristics accepted, or a new upper address pair loaded.
  task automatic load_ahi(input logic ld, input logic [1:0] val);
    @(negedge clk_i);
    nba_clr_o = ~ld;
    ahi_ld_o = ld;
    ahi_o = val;
    @(negedge clk_i);
    nba_clr_o = 1'b0;
    ahi_ld_o = 1'b0;
  endtask
endmodule

// >>> tb/test_tape_subsystem_status_register.sv
// Self-checking bench for the tape subsystem status register.
`timescale 1ns/1ps
module test_tape_subsystem_status_register;
  logic        clk, rst, sel, wr, rd, bw, ack, init, ld;
  logic [1:0]  addr;
  logic [15:0] wd, rdat, got;
  logic [17:0] ptr;
  logic        x_end, x_sc, x_idle, x_nba, x_ald, x_ofl;
  logic [2:0]  x_tc, x_ev;
  logic [1:0]  x_fc, x_ahi;
  int          bad_count, total_checks, cycles, i;
  logic [15:0] ev_exp [3] = '{16'hc400, 16'ha42e, 16'h8c00};
  logic [15:0] ld_exp [3] = '{16'h9400, 16'h942e, 16'h9400};
  // ==========================================
  // Clock, reset and the design under test.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  tss_xpt_model xpt (.clk_i(clk), .end_o(x_end), .sc_o(x_sc), .tc_o(x_tc), .fc_o(x_fc),
    .idle_o(x_idle), .nba_clr_o(x_nba), .ahi_ld_o(x_ald), .ahi_o(x_ahi), .ofl_o(x_ofl),
    .ev_o(x_ev));
  tss_status_top uut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .HOST_SEL_I(sel), .HOST_WR_I(wr),
    .HOST_RD_I(rd), .HOST_BYTE_I(bw), .HOST_ADDR_I(addr), .HOST_WDATA_I(wd),
    .HOST_RDATA_O(rdat), .HOST_ACK_O(ack), .XPT_END_I(x_end), .XPT_SC_I(x_sc),
    .XPT_TC_I(x_tc), .XPT_FC_I(x_fc), .XPT_IDLE_I(x_idle), .XPT_NBA_CLR_I(x_nba),
    .XPT_AHI_LD_I(x_ald), .XPT_AHI_I(x_ahi), .OFFLINE_PIN_I(x_ofl), .UPE_EV_I(x_ev[0]),
    .SPE_EV_I(x_ev[1]), .NXM_EV_I(x_ev[2]), .INIT_O(init), .CMD_LD_O(ld), .CMD_PTR_O(ptr));
  // Compare and count; an unknown never matches.
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One access: strobe for one cycle, then answer is looked at the cycle after.
  task automatic acc(input logic w, input logic b, input logic [1:0] a, input logic [15:0] d);
    @(negedge clk);
    {sel, wr, rd, bw, addr, wd} = {1'b1, w, ~w, b, a, d};
    @(negedge clk);
    {sel, wr, rd} = 3'h0;
    got = rdat;
    chk(ack, 1'b1);
  endtask
  // Single-point ending for both normal end and hang.
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Cycle ceiling well above the hundred or so cycles the tests need.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  // ==========================================
  // Test sequence.
  initial
  begin
    {rst, sel, wr, rd, bw, addr, wd} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h0400);
    acc(1'b0, 1'b0, 2'h0, 16'h0); chk(got, 16'h0000);
    $display("test reset done");
    // Each error event, then a buffer load while busy, then initialize.
    for (i = 0; i < 3; i++)
    begin
      xpt.pulse_ev(i);
      acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, ev_exp[i]);
      acc(1'b1, 1'b0, 2'h0, 16'h0004); chk(ld, 1'b1);
      acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, ld_exp[i]);
      acc(1'b1, 1'b0, 2'h2, 16'hffff); chk(init, 1'b1);
      acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h0400);
    end
    $display("test events done");
    xpt.end_cmd(1'b1, 3'h7, 2'h1);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h841e);
    xpt.end_cmd(1'b1, 3'h2, 2'h3);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h8404);
    xpt.load_ahi(1'b0, 2'h0);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h8004);
    acc(1'b1, 1'b0, 2'h2, 16'h0); chk(init, 1'b1);
    $display("test class done");
    // Ready follows idle; a load while ready is not refused.
    xpt.idle_o = 1'b1;
    repeat (2) @(negedge clk);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h0480);
    acc(1'b1, 1'b0, 2'h0, 16'h1235); chk(ptr, {2'h1, 14'h048d, 2'h0});
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h0580);
    xpt.ofl_o = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h05c0);
    xpt.ofl_o = 1'b0;
    xpt.load_ahi(1'b1, 2'h2);
    repeat (4) @(negedge clk);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h0680);
    $display("test ready done");
    // A byte write to status is an initialize and sets nothing.
    xpt.idle_o = 1'b0;
    acc(1'b1, 1'b1, 2'h2, 16'hffff); chk(init, 1'b1);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h0600);
    $display("test byte done");
    // Buffer byte writes: the odd byte loads the high address pair and is
    // refused while busy; the even byte only clears the flags.
    acc(1'b1, 1'b1, 2'h1, 16'h0100); chk(ld, 1'b0);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h9500);
    acc(1'b1, 1'b1, 2'h0, 16'h00ff); chk(ld, 1'b0);
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h8500);
    $display("test buffer bytes done");
    // A reset in mid-run brings back the power-up word.
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, 1'b0, 2'h2, 16'h0); chk(got, 16'h0400);
    $display("test reset again done");
    end_of_test();
  end
endmodule
